// ==== rtl/ccd_pkg.sv ====
// Package for the channel clock divider set: register map, field
// positions, reset values and the per-stage configuration carrier.
// Assumes a 32-bit APB master whose byte address is four times the
// register index.
package ccd_pkg;

  localparam int NREG = 19;
  localparam int IDX_W = 10;
  localparam int ADDR_W = 12;

  // Register indices; byte address is index times four
  localparam logic [IDX_W-1:0] IDX_DIV0_WIDTHS = 10'h190;
  localparam logic [IDX_W-1:0] IDX_DIV0_BYPASS_PHASE = 10'h191;
  localparam logic [IDX_W-1:0] IDX_DIV0_DUTY_CONTROL = 10'h192;
  localparam logic [IDX_W-1:0] IDX_DIV1_WIDTHS = 10'h193;
  localparam logic [IDX_W-1:0] IDX_DIV1_BYPASS_PHASE = 10'h194;
  localparam logic [IDX_W-1:0] IDX_DIV1_DUTY_CONTROL = 10'h195;
  localparam logic [IDX_W-1:0] IDX_DIV2_WIDTHS = 10'h196;
  localparam logic [IDX_W-1:0] IDX_DIV2_BYPASS_PHASE = 10'h197;
  localparam logic [IDX_W-1:0] IDX_DIV2_DUTY_CONTROL = 10'h198;
  localparam logic [IDX_W-1:0] IDX_DIV3_STAGE1_WIDTHS = 10'h199;
  localparam logic [IDX_W-1:0] IDX_DIV3_STAGE2_WIDTHS = 10'h19B;
  localparam logic [IDX_W-1:0] IDX_DIV3_STAGE_BYPASS = 10'h19C;
  localparam logic [IDX_W-1:0] IDX_DIV3_DUTY_CONTROL = 10'h19D;
  localparam logic [IDX_W-1:0] IDX_DIV4_STAGE1_WIDTHS = 10'h19E;
  localparam logic [IDX_W-1:0] IDX_DIV4_STAGE2_WIDTHS = 10'h1A0;
  localparam logic [IDX_W-1:0] IDX_DIV4_STAGE_BYPASS = 10'h1A1;
  localparam logic [IDX_W-1:0] IDX_DIV4_DUTY_CONTROL = 10'h1A2;
  localparam logic [IDX_W-1:0] IDX_CTRL = 10'h1B0;
  localparam logic [IDX_W-1:0] IDX_STATUS = 10'h1B1;

  // Slot order inside the register array follows this table
  localparam logic [IDX_W-1:0] REG_IDX [NREG] = '{
    IDX_DIV0_WIDTHS, IDX_DIV0_BYPASS_PHASE, IDX_DIV0_DUTY_CONTROL,
    IDX_DIV1_WIDTHS, IDX_DIV1_BYPASS_PHASE, IDX_DIV1_DUTY_CONTROL,
    IDX_DIV2_WIDTHS, IDX_DIV2_BYPASS_PHASE, IDX_DIV2_DUTY_CONTROL,
    IDX_DIV3_STAGE1_WIDTHS, IDX_DIV3_STAGE2_WIDTHS,
    IDX_DIV3_STAGE_BYPASS, IDX_DIV3_DUTY_CONTROL,
    IDX_DIV4_STAGE1_WIDTHS, IDX_DIV4_STAGE2_WIDTHS,
    IDX_DIV4_STAGE_BYPASS, IDX_DIV4_DUTY_CONTROL,
    IDX_CTRL, IDX_STATUS
  };
  localparam int SLOT_CH0 = 0;
  localparam int SLOTS_PER_SINGLE = 3;
  localparam int SLOT_CH3 = 9;
  localparam int SLOTS_PER_CASCADE = 4;
  localparam int SLOT_CTRL = 17;
  localparam int SLOT_STATUS = 18;

  // Field positions
  localparam int LOW_MSB = 7;
  localparam int LOW_LSB = 4;
  localparam int HIGH_MSB = 3;
  localparam int HIGH_LSB = 0;
  localparam int BIT_BYPASS = 7;
  localparam int BIT_RISE_FIRST = 4;
  localparam int DELAY_MSB = 3;
  localparam int BIT_FIX_OFF = 0;
  localparam int BIT_S1_BYPASS = 4;
  localparam int BIT_S2_BYPASS = 5;
  localparam int BIT_REALIGN = 0;
  localparam int BEN_LSB = 4;
  localparam int BEN_MSB = 7;

  // Reset values
  localparam logic [7:0] RST_REG = 8'h00;

  // Phase code weight of the rise_first bit
  localparam logic [5:0] PHASE_SPLIT = 6'h10;

  typedef struct packed {
    logic [3:0] low_width;
    logic [3:0] high_width;
    logic bypass;
    logic duty_fix_off;
    logic rise_first;
    logic [3:0] delay_code_bits;
  } ccd_stage_cfg_t;

  typedef enum logic [1:0] {
    ST_WAIT = 2'b00,
    ST_HIGH = 2'b01,
    ST_LOW = 2'b10
  } ccd_state_t;

endpackage

// ==== rtl/ccd_stage.sv ====
// One divider stage: counts input edges into high and low widths.
// Assumes in_rise pulses once per input period in the CLK domain and
// that restart is a one-cycle pulse from the register block.
module ccd_stage (
  input wire logic clk, // Divider input clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic restart, // Realign pulse
  input wire logic in_rise, // One pulse per input period
  input wire logic in_lvl, // Input level, used when bypassed
  input wire ccd_pkg::ccd_stage_cfg_t cfg, // Programmed settings
  output logic out_lvl, // Divided level
  output logic out_rise // Pulse on each output rising edge
);

  ccd_pkg::ccd_state_t state, next_state;
  logic [5:0] cnt, next_cnt;
  logic [3:0] cur_lo, next_cur_lo;
  logic [3:0] cur_hi, next_cur_hi;
  logic cur_byp, next_cur_byp;
  logic cur_fix_off, next_cur_fix_off;
  logic next_out_lvl, next_out_rise;
  logic [5:0] new_delay;

  function automatic logic [5:0] ratio(input logic [3:0] lo,
                                       input logic [3:0] hi);
    ratio = 6'(lo) + 6'(hi) + 6'h02;
  endfunction

  // High time in input periods; correction gives high half the ratio, rounded down
  function automatic logic [5:0] hi_len(input logic [3:0] lo,
                                        input logic [3:0] hi,
                                        input logic fix_off);
    if (fix_off) begin
      hi_len = 6'(hi) + 6'h01; // [R1] [R7]
    end else begin
      hi_len = ratio(lo, hi) >> 1; // [R5] [R6] [R8] [R9]
    end
  endfunction

  function automatic logic [5:0] lo_len(input logic [3:0] lo,
                                        input logic [3:0] hi,
                                        input logic fix_off);
    lo_len = ratio(lo, hi) - hi_len(lo, hi, fix_off); // [R1] [R2]
  endfunction

  always_comb begin
    if (cfg.rise_first) begin
      new_delay = 6'(cfg.delay_code_bits) + 6'(cfg.low_width)
                  + 6'h01; // [R13]
    end else begin
      new_delay = 6'(cfg.delay_code_bits); // [R12]
    end
  end

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_cur_lo = cur_lo;
    next_cur_hi = cur_hi;
    next_cur_byp = cur_byp;
    next_cur_fix_off = cur_fix_off;
    next_out_lvl = out_lvl;
    next_out_rise = 1'b0;
    if (restart) begin
      // Phase is only loaded here, so a new offset waits for realign
      next_cur_lo = cfg.low_width; // [R14] [R23]
      next_cur_hi = cfg.high_width;
      next_cur_byp = cfg.bypass;
      next_cur_fix_off = cfg.duty_fix_off;
      next_state = ccd_pkg::ST_WAIT;
      next_cnt = new_delay;
      next_out_lvl = 1'b0;
    end else if (cur_byp) begin
      next_out_lvl = in_lvl; // [R3] [R10] [R11]
      next_out_rise = in_rise;
      next_cur_lo = cfg.low_width;
      next_cur_hi = cfg.high_width;
      next_cur_fix_off = cfg.duty_fix_off;
      if (!cfg.bypass && in_rise) begin
        next_cur_byp = 1'b0;
        next_state = ccd_pkg::ST_WAIT;
        next_cnt = 6'h00;
        next_out_lvl = 1'b0;
        next_out_rise = 1'b0;
      end
    end else if (in_rise) begin // [R4]
      unique case (state)
        ccd_pkg::ST_WAIT: begin
          if (cnt == 6'h00) begin
            next_state = ccd_pkg::ST_HIGH;
            next_cnt = hi_len(cur_lo, cur_hi, cur_fix_off) - 6'h01;
            next_out_lvl = 1'b1;
            next_out_rise = 1'b1;
          end else begin
            next_cnt = cnt - 6'h01;
          end
        end
        ccd_pkg::ST_HIGH: begin
          if (cnt == 6'h00) begin
            next_state = ccd_pkg::ST_LOW;
            next_cnt = lo_len(cur_lo, cur_hi, cur_fix_off) - 6'h01;
            next_out_lvl = 1'b0;
          end else begin
            next_cnt = cnt - 6'h01;
          end
        end
        ccd_pkg::ST_LOW: begin
          if (cnt != 6'h00) begin
            next_cnt = cnt - 6'h01;
          end else begin
            // Period boundary: new settings apply here, no runt pulses
            next_cur_lo = cfg.low_width; // [R24]
            next_cur_hi = cfg.high_width;
            next_cur_fix_off = cfg.duty_fix_off;
            next_cur_byp = cfg.bypass;
            if (cfg.bypass) begin
              next_out_lvl = in_lvl; // [R3]
              next_out_rise = 1'b1;
            end else begin
              next_state = ccd_pkg::ST_HIGH;
              next_cnt = hi_len(cfg.low_width, cfg.high_width,
                                cfg.duty_fix_off) - 6'h01;
              next_out_lvl = 1'b1;
              next_out_rise = 1'b1;
            end
          end
        end
        default: begin
          next_state = ccd_pkg::ST_WAIT;
          next_cnt = 6'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ccd_pkg::ST_WAIT;
      cnt <= 6'h00;
      cur_lo <= 4'h0;
      cur_hi <= 4'h0;
      cur_byp <= 1'b0;
      cur_fix_off <= 1'b0;
      out_lvl <= 1'b0;
      out_rise <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      cur_lo <= next_cur_lo;
      cur_hi <= next_cur_hi;
      cur_byp <= next_cur_byp;
      cur_fix_off <= next_cur_fix_off;
      out_lvl <= next_out_lvl;
      out_rise <= next_out_rise;
    end
  end

  // Helper for the period check: input edges between output rises
  logic [5:0] per_cnt;
  logic seen;
  logic chk_valid;
  logic [5:0] chk_cnt;
  logic [5:0] chk_d;
  always_ff @(posedge clk) begin
    if (rst || restart || cur_byp) begin
      per_cnt <= 6'h00;
      seen <= 1'b0;
      chk_valid <= 1'b0;
      chk_cnt <= 6'h00;
      chk_d <= 6'h00;
    end else begin
      chk_valid <= next_out_rise && seen && !next_cur_byp;
      chk_cnt <= per_cnt + 6'(in_rise);
      chk_d <= ratio(cur_lo, cur_hi);
      if (next_out_rise) begin
        per_cnt <= 6'h00;
        seen <= 1'b1;
      end else begin
        per_cnt <= per_cnt + 6'(in_rise);
      end
    end
  end

  property p_period;
    @(posedge clk) disable iff (rst)
      chk_valid |-> chk_cnt == chk_d;
  endproperty
  a_period: assert property (p_period) // [R2]
    else $error("Output period differs from programmed ratio");

  property p_restart_low;
    @(posedge clk) disable iff (rst)
      restart |=> !out_lvl && !out_rise;
  endproperty
  a_restart_low: assert property (p_restart_low) // [R23]
    else $error("Output not low after realign");

  property p_bypass_follow;
    @(posedge clk) disable iff (rst)
      cur_byp && !restart && !(!cfg.bypass && in_rise)
        |=> out_lvl == $past(in_lvl);
  endproperty
  a_bypass_follow: assert property (p_bypass_follow) // [R3]
    else $error("Bypassed stage does not follow its input");

  sequence s_zero_delay_start;
    restart && !cfg.bypass && !cfg.rise_first
      && cfg.delay_code_bits == 4'h0 && in_rise;
  endsequence
  property p_zero_delay;
    @(posedge clk) disable iff (rst)
      s_zero_delay_start ##1 in_rise |=> out_rise;
  endproperty
  a_zero_delay: assert property (p_zero_delay) // [R12]
    else $error("Zero phase code did not rise on first input edge");

endmodule

// ==== rtl/ccd_top.sv ====
// Channel clock divider set: APB register block, three single-stage
// channels and two cascaded channels with split A/B outputs.
// Assumes CLK is the clock routed to the divider input and that the
// APB master runs on the same clock.
//
// How it works
// R1: Widths hold cycles minus one; low lasts low+1, high lasts high+1.
// R2: Unbypassed single stage divides by high+low+2, from 2 to 32.
// R3: Bypass passes the input through as divide-by-one, counter idle.
// R4: Every count is in periods of the divider input clock.
// R5: Duty correction on by default; duty_fix_off per channel disables.
// R6: Correction gives 50%; software programs matching width pairs.
// R7: Uncorrected duty is (high+1)/(high+low+2).
// R8: Prescaled bypass duty depends on prescale; correction evens it.
// R9: Odd prescale and odd ratio corrected give the printed fractions.
// R10: Without prescale, bypass keeps input duty; odd corrected mixes.
// R11: Direct routing keeps the source duty cycle.
// R12: Phase code is 16*rise_first+delay; small codes delay by code.
// R13: With rise_first, delay is code-16+low+1 input cycles.
// R14: New phase offsets apply only after a realign pulse.
// R15: Channels three and four cascade two stages; ratio is product.
// R16: Both bypassed gives one; second bypassed gives first ratio.
// R17: Software uses the first stage alone, never only the second.
// R18: One duty_fix_off bit per cascaded channel covers both stages.
// R19: Cascaded outputs split into A and B; B off after reset.
// R20: Three single-stage dividers, each driving one differential pair.
// R21: Prescaler ahead of the channels divides by 2 to 6; there is no prescaler here, and every CLK cycle is one input period.
// R22: Software puts lone bypass or even ratio on the second stage.
// R23: Realign restarts all dividers low, then applies phase delay.
// R24: Width, bypass and correction changes wait for a period boundary.
//
// Register access over APB was chosen for this implementation.
module ccd_top #(
  parameter int NSINGLE = 3, // Single-stage channels
  parameter int NCASC = 2 // Cascaded channels
) (
  input wire logic CLK, // Divider input clock
  input wire logic RST, // Synchronous reset, active high
  input wire logic PSEL, // APB select
  input wire logic PENABLE, // APB enable
  input wire logic PWRITE, // APB write
  input wire logic [ccd_pkg::ADDR_W-1:0] PADDR, // APB byte address
  input wire logic [31:0] PWDATA, // APB write data
  output logic [31:0] PRDATA, // APB read data
  output logic PREADY, // APB ready
  output logic PSLVERR, // APB error, unmapped address
  output logic [NSINGLE-1:0] DIFF_OUT, // Single-stage channel levels
  output logic [NSINGLE-1:0] DIFF_RISE, // Rising-edge pulses
  output logic [2*NCASC-1:0] SPLIT_A, // Cascaded outputs, A side
  output logic [2*NCASC-1:0] SPLIT_B, // Cascaded outputs, B side
  output logic [NCASC-1:0] SPLIT_RISE // Cascaded rising-edge pulses
);

  localparam int NCH = NSINGLE + NCASC;

  logic [7:0] regs [ccd_pkg::NREG];
  logic [7:0] next_regs [ccd_pkg::NREG];
  logic next_pready, next_pslverr;
  logic [31:0] next_prdata;
  logic realign, next_realign;
  logic [NCH-1:0] ch_lvl, ch_rise;
  logic [NSINGLE-1:0] next_diff_out, next_diff_rise;
  logic [2*NCASC-1:0] next_split_a, next_split_b;
  logic [NCASC-1:0] next_split_rise;

  logic [ccd_pkg::IDX_W-1:0] idx;
  logic hit;
  logic [4:0] slot;
  logic ack;

  // Unaligned addresses count as unmapped
  always_comb begin
    idx = PADDR[ccd_pkg::ADDR_W-1:2];
    hit = 1'b0;
    slot = 5'h00;
    for (int i = 0; i < ccd_pkg::NREG; i++) begin
      if (PADDR[1:0] == 2'b00 && idx == ccd_pkg::REG_IDX[i]) begin
        hit = 1'b1;
        slot = 5'(i);
      end
    end
  end

  assign ack = PSEL && PENABLE && PREADY;

  // Bus answer: one wait state, then ready for exactly one cycle
  always_comb begin
    next_pready = PSEL && PENABLE && !PREADY;
    next_pslverr = 1'b0;
    next_prdata = PRDATA;
    if (PSEL && PENABLE && !PREADY) begin
      next_pslverr = !hit;
      next_prdata = 32'h0000_0000;
      if (hit) begin
        next_prdata = {24'h00_0000, regs[slot]};
      end
    end
  end

  always_comb begin
    for (int i = 0; i < ccd_pkg::NREG; i++) begin
      next_regs[i] = regs[i];
    end
    next_realign = 1'b0;
    if (ack && PWRITE && hit && slot != 5'(ccd_pkg::SLOT_STATUS)) begin
      next_regs[slot] = PWDATA[7:0];
      if (slot == 5'(ccd_pkg::SLOT_CTRL)) begin
        // Realign is a command, not state: it reads back as zero
        next_regs[slot][ccd_pkg::BIT_REALIGN] = 1'b0;
        next_realign = PWDATA[ccd_pkg::BIT_REALIGN]; // [R14]
      end
    end
    next_regs[ccd_pkg::SLOT_STATUS] = {{(8 - NCH){1'b0}}, ch_lvl};
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      for (int i = 0; i < ccd_pkg::NREG; i++) begin
        regs[i] <= ccd_pkg::RST_REG; // [R5] [R19]
      end
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
      realign <= 1'b0;
    end else begin
      for (int i = 0; i < ccd_pkg::NREG; i++) begin
        regs[i] <= next_regs[i];
      end
      PREADY <= next_pready;
      PSLVERR <= next_pslverr;
      PRDATA <= next_prdata;
      realign <= next_realign;
    end
  end

  // Single-stage channels
  genvar g;
  generate
    for (g = 0; g < NSINGLE; g++) begin : g_single
      localparam int SB = ccd_pkg::SLOT_CH0 + g * ccd_pkg::SLOTS_PER_SINGLE;
      ccd_pkg::ccd_stage_cfg_t cfg;
      always_comb begin
        cfg.low_width = regs[SB][ccd_pkg::LOW_MSB:ccd_pkg::LOW_LSB]; // [R1]
        cfg.high_width = regs[SB][ccd_pkg::HIGH_MSB:ccd_pkg::HIGH_LSB];
        cfg.bypass = regs[SB + 1][ccd_pkg::BIT_BYPASS]; // [R3]
        cfg.rise_first = regs[SB + 1][ccd_pkg::BIT_RISE_FIRST]; // [R12]
        cfg.delay_code_bits = regs[SB + 1][ccd_pkg::DELAY_MSB:0];
        cfg.duty_fix_off = regs[SB + 2][ccd_pkg::BIT_FIX_OFF]; // [R5]
      end
      ccd_stage u_stage (
        .clk(CLK),
        .rst(RST),
        .restart(realign), // [R23]
        .in_rise(1'b1), // [R21]
        .in_lvl(1'b1),
        .cfg(cfg),
        .out_lvl(ch_lvl[g]), // [R20]
        .out_rise(ch_rise[g])
      );
    end
  endgenerate

  // Cascaded channels; the second stage counts first-stage rises
  generate
    for (g = 0; g < NCASC; g++) begin : g_casc
      localparam int SB = ccd_pkg::SLOT_CH3 + g * ccd_pkg::SLOTS_PER_CASCADE;
      ccd_pkg::ccd_stage_cfg_t cfg1, cfg2;
      logic s1_lvl, s1_rise;
      always_comb begin
        cfg1.low_width = regs[SB][ccd_pkg::LOW_MSB:ccd_pkg::LOW_LSB];
        cfg1.high_width = regs[SB][ccd_pkg::HIGH_MSB:ccd_pkg::HIGH_LSB];
        cfg1.bypass = regs[SB + 2][ccd_pkg::BIT_S1_BYPASS]; // [R16]
        cfg1.duty_fix_off = regs[SB + 3][ccd_pkg::BIT_FIX_OFF]; // [R18]
        cfg1.rise_first = 1'b0;
        cfg1.delay_code_bits = 4'h0;
        cfg2.low_width = regs[SB + 1][ccd_pkg::LOW_MSB:ccd_pkg::LOW_LSB];
        cfg2.high_width = regs[SB + 1][ccd_pkg::HIGH_MSB:ccd_pkg::HIGH_LSB];
        cfg2.bypass = regs[SB + 2][ccd_pkg::BIT_S2_BYPASS]; // [R16]
        cfg2.duty_fix_off = regs[SB + 3][ccd_pkg::BIT_FIX_OFF]; // [R18]
        cfg2.rise_first = 1'b0;
        cfg2.delay_code_bits = 4'h0;
      end
      ccd_stage u_first (
        .clk(CLK),
        .rst(RST),
        .restart(realign),
        .in_rise(1'b1),
        .in_lvl(1'b1),
        .cfg(cfg1),
        .out_lvl(s1_lvl),
        .out_rise(s1_rise)
      );
      ccd_stage u_second (
        .clk(CLK),
        .rst(RST),
        .restart(realign),
        .in_rise(s1_rise), // [R15]
        .in_lvl(s1_lvl),
        .cfg(cfg2),
        .out_lvl(ch_lvl[NSINGLE + g]),
        .out_rise(ch_rise[NSINGLE + g])
      );
    end
  endgenerate

  // Output pins; B sides stay low until software enables them
  always_comb begin
    next_diff_out = ch_lvl[NSINGLE-1:0];
    next_diff_rise = ch_rise[NSINGLE-1:0];
    next_split_rise = ch_rise[NCH-1:NSINGLE];
    for (int c = 0; c < NCASC; c++) begin
      for (int k = 0; k < 2; k++) begin
        next_split_a[2*c + k] = ch_lvl[NSINGLE + c]; // [R19]
        next_split_b[2*c + k] = ch_lvl[NSINGLE + c]
          && regs[ccd_pkg::SLOT_CTRL][ccd_pkg::BEN_LSB + 2*c + k];
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      DIFF_OUT <= '0;
      DIFF_RISE <= '0;
      SPLIT_A <= '0;
      SPLIT_B <= '0; // [R19]
      SPLIT_RISE <= '0;
    end else begin
      DIFF_OUT <= next_diff_out;
      DIFF_RISE <= next_diff_rise;
      SPLIT_A <= next_split_a;
      SPLIT_B <= next_split_b;
      SPLIT_RISE <= next_split_rise;
    end
  end

  property p_ready_after_wait;
    @(posedge CLK) disable iff (RST)
      PSEL && PENABLE && !PREADY |=> PREADY;
  endproperty
  a_ready_after_wait: assert property (p_ready_after_wait)
    else $error("APB access not answered after one wait state");

  property p_write_takes;
    @(posedge CLK) disable iff (RST)
      ack && PWRITE && PADDR == 12'(ccd_pkg::IDX_DIV0_WIDTHS * 4)
        |=> regs[ccd_pkg::SLOT_CH0] == $past(PWDATA[7:0]);
  endproperty
  a_write_takes: assert property (p_write_takes) // [R1]
    else $error("Width register did not take written value");

  property p_b_off_after_reset;
    @(posedge CLK) $past(RST) |-> SPLIT_B == '0;
  endproperty
  a_b_off_after_reset: assert property (p_b_off_after_reset) // [R19]
    else $error("B output active right after reset");

  property p_realign_all_low;
    @(posedge CLK) disable iff (RST)
      realign |=> ##1 DIFF_OUT == '0 && SPLIT_A == '0;
  endproperty
  a_realign_all_low: assert property (p_realign_all_low) // [R23]
    else $error("Outputs not low after realign");

endmodule

// ==== verif/ccd_sink.sv ====
// Far-side receiver model: times each period of one output channel.
// Assumes lvl and rise come from one registered channel pin pair.
module ccd_sink (
  input wire logic clk, // Divider input clock
  input wire logic rst, // Synchronous reset
  input wire logic lvl, // Channel level
  input wire logic rise, // Rising-edge pulse
  output logic valid, // One cycle per whole period
  output logic [11:0] per, // Cycles rise to rise
  output logic [11:0] hi // High cycles in that period
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] cnt;
  logic [11:0] hcnt;
  logic seen;
  // The first rise only arms the counters: a part period is no result
  always @(posedge clk) begin
    valid <= 1'b0;
    if (rst) begin
      seen <= 1'b0;
      cnt <= 12'h000;
    end else if (rise) begin
      valid <= seen;
      per <= cnt;
      hi <= hcnt;
      cnt <= 12'h001;
      hcnt <= 12'h001;
      seen <= 1'b1;
    end else begin
      cnt <= cnt + 12'h001;
      hcnt <= hcnt + {11'h000, lvl};
    end
  end
endmodule

// ==== verif/channel_clock_divider_set_tb.sv ====
// Self-checking bench: APB register traffic and measured channel periods.
// Assumes the ccd_top port list and one 100 MHz clock.
module channel_clock_divider_set_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0;
  logic PWRITE = 1'b0, PREADY, PSLVERR;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0, PRDATA;
  logic [2:0] DIFF_OUT, DIFF_RISE;
  logic [3:0] SPLIT_A, SPLIT_B;
  logic [1:0] SPLIT_RISE;
  logic v0, v3;
  logic [11:0] p0, h0, p3, h3;
  logic [33:0] bus_q[$], bn;
  logic [23:0] c0_q[$], c3_q[$];
  logic [7:0] w, wt [4] = '{8'h00, 8'h31, 8'hF0, 8'hFF};
  logic [7:0] pt [3] = '{8'h05, 8'h0F, 8'h12};
  logic [11:0] pe [3] = '{12'h005, 12'h00F, 12'h004};
  int n_fail = 0, check_count = 0, cyc = 0, seed = 9480, i, base, got;

  always #5 CLK = ~CLK;

  ccd_top uut (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .DIFF_OUT(DIFF_OUT),
    .DIFF_RISE(DIFF_RISE), .SPLIT_A(SPLIT_A), .SPLIT_B(SPLIT_B),
    .SPLIT_RISE(SPLIT_RISE));
  ccd_sink s0 (.clk(CLK), .rst(RST), .lvl(DIFF_OUT[0]),
    .rise(DIFF_RISE[0]), .valid(v0), .per(p0), .hi(h0));
  ccd_sink s3 (.clk(CLK), .rst(RST), .lvl(SPLIT_A[0]),
    .rise(SPLIT_RISE[0]), .valid(v3), .per(p3), .hi(h3));

  task automatic chk(string n, logic [32:0] e, logic [32:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Note word: [33] read data checked, [32] error expected, [31:0] data
  task automatic apb(logic wr, logic [11:0] a, logic [7:0] d,
                     logic [33:0] e);
    bus_q.push_back(e);
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= {24'h0, d};
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1) @(posedge CLK);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic wr(logic [9:0] x, logic [7:0] d);
    apb(1'b1, {x, 2'b00}, d, 34'h0);
  endtask

  task automatic rd(logic [9:0] x, logic [7:0] d);
    apb(1'b0, {x, 2'b00}, 8'h00, {2'b10, 24'h0, d});
  endtask

  // Settle past two long periods, then note the expected period shape
  task automatic exp_clk(logic c3, logic [11:0] h, logic [11:0] p);
    wr(ccd_pkg::IDX_CTRL, 8'h01);
    repeat (70) @(posedge CLK);
    @(negedge CLK);
    if (c3) c3_q.push_back({h, p});
    else c0_q.push_back({h, p});
    while (c0_q.size() + c3_q.size() > 0) @(posedge CLK);
  endtask

  task automatic phase(logic [7:0] c);
    wr(ccd_pkg::IDX_DIV0_BYPASS_PHASE, c);
    wr(ccd_pkg::IDX_CTRL, 8'h01);
    got = 0;
    // The first two edges still show rises from before the realign
    repeat (2) @(posedge CLK);
    do begin
      @(posedge CLK);
      got++;
    end while (DIFF_RISE[0] !== 1'b1 && got < 200);
  endtask

  always @(posedge CLK) begin
    if (PREADY === 1'b1 && bus_q.size() > 0) begin
      bn = bus_q.pop_front();
      chk("apb", bn[32:0], {PSLVERR, bn[33] ? PRDATA : bn[31:0]});
    end
    if (v0 === 1'b1 && c0_q.size() > 0)
      chk("ch0", {9'h0, c0_q.pop_front()}, {9'h0, h0, p0});
    if (v3 === 1'b1 && c3_q.size() > 0)
      chk("ch3", {9'h0, c3_q.pop_front()}, {9'h0, h3, p3});
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      end_sim();
    end
  end

  initial begin
    repeat (3) @(posedge CLK);
    RST <= 1'b0;
    // Status shows running levels here; it is read once all are bypassed
    for (i = 0; i < 18; i++) rd(ccd_pkg::REG_IDX[i], 8'h00);
    w = 8'($random(seed));
    wr(ccd_pkg::IDX_DIV1_WIDTHS, w);
    rd(ccd_pkg::IDX_DIV1_WIDTHS, w);
    apb(1'b1, 12'hFFC, 8'h5A, {2'b01, 32'h0});
    apb(1'b0, 12'h641, 8'h00, {2'b11, 32'h0});
    wr(ccd_pkg::IDX_DIV0_DUTY_CONTROL, 8'h01);
    for (i = 0; i < 7; i++) begin
      w = (i < 4) ? wt[i] : 8'($random(seed));
      wr(ccd_pkg::IDX_DIV0_WIDTHS, w);
      exp_clk(1'b0, w[3:0] + 12'h1, w[3:0] + w[7:4] + 12'h2);
    end
    wr(ccd_pkg::IDX_DIV0_DUTY_CONTROL, 8'h00);
    wr(ccd_pkg::IDX_DIV0_WIDTHS, 8'h21);
    exp_clk(1'b0, 12'h002, 12'h005);
    wr(ccd_pkg::IDX_DIV0_DUTY_CONTROL, 8'h01);
    wr(ccd_pkg::IDX_DIV0_WIDTHS, 8'h11);
    phase(8'h00);
    base = got;
    for (i = 0; i < 3; i++) begin
      phase(pt[i]);
      chk("phase", 33'(pe[i]), 33'(got - base));
    end
    wr(ccd_pkg::IDX_DIV3_DUTY_CONTROL, 8'h01);
    wr(ccd_pkg::IDX_DIV3_STAGE1_WIDTHS, 8'h10);
    wr(ccd_pkg::IDX_DIV3_STAGE2_WIDTHS, 8'h11);
    exp_clk(1'b1, 12'h006, 12'h00C);
    wr(ccd_pkg::IDX_DIV3_STAGE_BYPASS, 8'h20);
    exp_clk(1'b1, 12'h001, 12'h003);
    wr(ccd_pkg::IDX_DIV3_STAGE_BYPASS, 8'h30);
    exp_clk(1'b1, 12'h001, 12'h001);
    wr(ccd_pkg::IDX_DIV3_STAGE_BYPASS, 8'h00);
    repeat (30) @(posedge CLK);
    chk("b_off", 33'h0, {29'h0, SPLIT_B});
    wr(ccd_pkg::IDX_CTRL, 8'h10);
    // The new enable reaches the B pin one edge after the write lands
    @(posedge CLK);
    for (i = 0; i < 12; i++) begin
      @(posedge CLK);
      chk("b_on", {32'h0, SPLIT_A[0]},
        {SPLIT_B[3:1], 29'h0, SPLIT_B[0]});
    end
    for (i = 0; i < 3; i++) wr(ccd_pkg::REG_IDX[3*i+1], 8'h80);
    wr(ccd_pkg::IDX_DIV3_STAGE_BYPASS, 8'h30);
    wr(ccd_pkg::IDX_DIV4_STAGE_BYPASS, 8'h30);
    repeat (40) @(posedge CLK);
    rd(ccd_pkg::IDX_STATUS, 8'h1F);
    end_sim();
  end
endmodule
